// >>> load_observer_config.sv
// Load observer configuration, gain hold and estimate outputs of a servo drive.
// Assumes the controller writes and reads parameters by index over a simple message port on clk_i.
// Functional notes
// - Mode resets to 0, observer inactive, no estimate injected.
// - Mode 1 gives torque estimate only.
// - Mode 2 gives torque and velocity estimates to the loops.
// - Mode 3 gives velocity estimate only as velocity feedback.
// - Mode 4 disconnects acceleration reference; acceleration feedback only.
// - Proportional and integral bandwidths come from separate writable parameters.
// - Feedback and input gains set internally from the mode, except the manual feedback gain in mode 4.
// - Manual feedback gain accepted only in mode 4, output limited to 200.
// - Proportional bandwidth held in rad/s, output limited to 12500.
// - Integral bandwidth held as 16-bit unsigned, 0 to 65535.
// - Written gains taken as unsigned 16-bit, negatives as bit pattern.
// - Acceleration estimate readable as 32-bit signed.
// - Torque estimate readable as 16-bit signed.
// - Override 0: filter 389 Hz when zero, else limited to 389 Hz.
// - Override 1 with zero bandwidth bypasses the filter.
// - Override 1 with nonzero bandwidth limits to 10430 Hz.
// - Observer takes acceleration reference and position feedback, estimates load deviation.
`timescale 1ns/10ps
module load_observer_config
  import observer_pkg::*;
(
  // Clock, reset and loop update enable.
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  // Parameter message port.
  input wire logic wr_en_i,
  input wire logic [PARAM_IDX_W-1:0] wr_idx_i,
  input wire logic [15:0] wr_data_i,
  input wire logic [PARAM_IDX_W-1:0] rd_idx_i,
  output logic [31:0] rd_data_o,
  // Estimator results and loop signals.
  input wire logic [31:0] accel_est_i,
  input wire logic signed [15:0] torque_est_i,
  // Observer configuration to the loop datapath.
  output logic [2:0] mode_o,
  output logic accel_ref_connect_o,
  output logic pos_fb_connect_o,
  output logic torque_est_apply_o,
  output logic vel_est_apply_o,
  output logic [15:0] prop_bw_o,
  output logic [15:0] int_bw_o,
  output logic [15:0] feedback_gain_o,
  output logic [15:0] input_gain_o,
  output logic lpf_bypass_o,
  output logic [15:0] lpf_bw_eff_o
);
  logic [2:0] mode_r, mode_nxt;
  logic [15:0] prop_bw_r, prop_bw_nxt;
  logic [15:0] int_bw_r, int_bw_nxt;
  logic [15:0] fb_gain_r, fb_gain_nxt;
  logic lpf_ovr_r, lpf_ovr_nxt;
  logic [15:0] lpf_bw_r, lpf_bw_nxt;
  logic [31:0] accel_est_r, accel_est_nxt;
  logic [15:0] torque_est_r, torque_est_nxt;
  logic [31:0] rd_data_r, rd_data_nxt;
  logic [2:0] mode_cfg_r, mode_cfg_nxt;
  logic ref_con_r, ref_con_nxt;
  logic pos_con_r, pos_con_nxt;
  logic tq_app_r, tq_app_nxt;
  logic vel_app_r, vel_app_nxt;
  logic [15:0] fbg_out_r, fbg_out_nxt;
  logic [15:0] ing_out_r, ing_out_nxt;
  logic byp_r, byp_nxt;
  logic [15:0] lpf_eff_r, lpf_eff_nxt;
  logic [15:0] pbw_out_r, pbw_out_nxt;
  logic [15:0] ibw_out_r, ibw_out_nxt;

  // Parameter store; out-of-range writes are not refused, as the controller validates them.
  always_comb begin
    mode_nxt = mode_r;
    prop_bw_nxt = prop_bw_r;
    int_bw_nxt = int_bw_r;
    fb_gain_nxt = fb_gain_r;
    lpf_ovr_nxt = lpf_ovr_r;
    lpf_bw_nxt = lpf_bw_r;
    if (wr_en_i) begin
      case (wr_idx_i)
        IDX_MODE: mode_nxt = wr_data_i[2:0];
        IDX_PROP_BW: prop_bw_nxt = wr_data_i;
        IDX_INT_BW: int_bw_nxt = wr_data_i;
        IDX_FB_GAIN: begin
          if (mode_r == MODE_ACCEL_FB) begin
            fb_gain_nxt = wr_data_i;
          end
        end
        IDX_LPF_OVERRIDE: lpf_ovr_nxt = wr_data_i[0];
        IDX_LPF_BW: lpf_bw_nxt = wr_data_i;
        default: mode_nxt = mode_r;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mode_r <= MODE_DISABLED;
      prop_bw_r <= GAIN_RESET;
      int_bw_r <= GAIN_RESET;
      fb_gain_r <= GAIN_RESET;
      lpf_ovr_r <= 1'b0;
      lpf_bw_r <= GAIN_RESET;
    end else if (clk_en_i) begin
      mode_r <= mode_nxt;
      prop_bw_r <= prop_bw_nxt;
      int_bw_r <= int_bw_nxt;
      fb_gain_r <= fb_gain_nxt;
      lpf_ovr_r <= lpf_ovr_nxt;
      lpf_bw_r <= lpf_bw_nxt;
    end
  end

  // Loop configuration, registered one update after the store so a write lands on the next update.
  always_comb begin
    mode_cfg_nxt = mode_r;
    ref_con_nxt = 1'b0;
    pos_con_nxt = 1'b0;
    tq_app_nxt = 1'b0;
    vel_app_nxt = 1'b0;
    fbg_out_nxt = AUTO_GAIN_OFF;
    ing_out_nxt = AUTO_GAIN_OFF;
    case (mode_r)
      MODE_DISABLED: begin
        tq_app_nxt = 1'b0;
      end
      MODE_TORQUE_ONLY: begin
        ref_con_nxt = 1'b1;
        pos_con_nxt = 1'b1;
        tq_app_nxt = 1'b1;
        fbg_out_nxt = AUTO_GAIN_ON;
        ing_out_nxt = AUTO_GAIN_ON;
      end
      MODE_TORQUE_VEL: begin
        ref_con_nxt = 1'b1;
        pos_con_nxt = 1'b1;
        tq_app_nxt = 1'b1;
        vel_app_nxt = 1'b1;
        fbg_out_nxt = AUTO_GAIN_ON;
        ing_out_nxt = AUTO_GAIN_ON;
      end
      MODE_VEL_ONLY: begin
        ref_con_nxt = 1'b1;
        pos_con_nxt = 1'b1;
        vel_app_nxt = 1'b1;
        fbg_out_nxt = AUTO_GAIN_ON;
        ing_out_nxt = AUTO_GAIN_ON;
      end
      MODE_ACCEL_FB: begin
        ref_con_nxt = 1'b0;
        pos_con_nxt = 1'b1;
        tq_app_nxt = 1'b1;
        fbg_out_nxt = (fb_gain_r > FB_GAIN_MAX) ? FB_GAIN_MAX : fb_gain_r;
        ing_out_nxt = AUTO_GAIN_OFF;
      end
      default: begin
        mode_cfg_nxt = MODE_DISABLED;
      end
    endcase
    pbw_out_nxt = (prop_bw_r > PROP_BW_MAX) ? PROP_BW_MAX : prop_bw_r;
    ibw_out_nxt = int_bw_r;
    byp_nxt = 1'b0;
    if (!lpf_ovr_r) begin
      if (lpf_bw_r == GAIN_RESET) begin
        lpf_eff_nxt = LPF_BW_LIMIT_STD;
      end else begin
        lpf_eff_nxt = (lpf_bw_r > LPF_BW_LIMIT_STD) ? LPF_BW_LIMIT_STD : lpf_bw_r;
      end
    end else if (lpf_bw_r == GAIN_RESET) begin
      byp_nxt = 1'b1;
      lpf_eff_nxt = GAIN_RESET;
    end else begin
      lpf_eff_nxt = (lpf_bw_r > LPF_BW_LIMIT_EXT) ? LPF_BW_LIMIT_EXT : lpf_bw_r;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mode_cfg_r <= MODE_DISABLED;
      ref_con_r <= 1'b0;
      pos_con_r <= 1'b0;
      tq_app_r <= 1'b0;
      vel_app_r <= 1'b0;
      fbg_out_r <= AUTO_GAIN_OFF;
      ing_out_r <= AUTO_GAIN_OFF;
      pbw_out_r <= GAIN_RESET;
      ibw_out_r <= GAIN_RESET;
      byp_r <= 1'b0;
      lpf_eff_r <= LPF_BW_LIMIT_STD;
    end else if (clk_en_i) begin
      mode_cfg_r <= mode_cfg_nxt;
      ref_con_r <= ref_con_nxt;
      pos_con_r <= pos_con_nxt;
      tq_app_r <= tq_app_nxt;
      vel_app_r <= vel_app_nxt;
      fbg_out_r <= fbg_out_nxt;
      ing_out_r <= ing_out_nxt;
      pbw_out_r <= pbw_out_nxt;
      ibw_out_r <= ibw_out_nxt;
      byp_r <= byp_nxt;
      lpf_eff_r <= lpf_eff_nxt;
    end
  end

  // Estimate capture and read port.
  always_comb begin
    accel_est_nxt = accel_est_i;
    torque_est_nxt = torque_est_i;
    case (rd_idx_i)
      IDX_MODE: rd_data_nxt = {29'h0000000, mode_r};
      IDX_PROP_BW: rd_data_nxt = {16'h0000, prop_bw_r};
      IDX_INT_BW: rd_data_nxt = {16'h0000, int_bw_r};
      IDX_FB_GAIN: rd_data_nxt = {16'h0000, fb_gain_r};
      IDX_ACCEL_EST: rd_data_nxt = accel_est_r;
      IDX_TORQUE_EST: rd_data_nxt = {{16{torque_est_r[15]}}, torque_est_r};
      IDX_LPF_OVERRIDE: rd_data_nxt = {31'h00000000, lpf_ovr_r};
      IDX_LPF_BW: rd_data_nxt = {16'h0000, lpf_bw_r};
      default: rd_data_nxt = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      accel_est_r <= 32'h00000000;
      torque_est_r <= 16'h0000;
      rd_data_r <= 32'h00000000;
    end else if (clk_en_i) begin
      accel_est_r <= accel_est_nxt;
      torque_est_r <= torque_est_nxt;
      rd_data_r <= rd_data_nxt;
    end
  end

  assign mode_o = mode_cfg_r;
  assign accel_ref_connect_o = ref_con_r;
  assign pos_fb_connect_o = pos_con_r;
  assign torque_est_apply_o = tq_app_r;
  assign vel_est_apply_o = vel_app_r;
  assign prop_bw_o = pbw_out_r;
  assign int_bw_o = ibw_out_r;
  assign feedback_gain_o = fbg_out_r;
  assign input_gain_o = ing_out_r;
  assign lpf_bypass_o = byp_r;
  assign lpf_bw_eff_o = lpf_eff_r;
  assign rd_data_o = rd_data_r;

  mode_disabled_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (mode_o == MODE_DISABLED) |-> (!torque_est_apply_o && !vel_est_apply_o))
    else $error("Disabled mode applies an estimate.");
  mode_torque_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (mode_o == MODE_TORQUE_ONLY) |-> (torque_est_apply_o && !vel_est_apply_o))
    else $error("Torque only mode output wrong.");
  mode_both_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (mode_o == MODE_TORQUE_VEL) |-> (torque_est_apply_o && vel_est_apply_o))
    else $error("Standard mode must apply both estimates.");
  mode_vel_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (mode_o == MODE_VEL_ONLY) |-> (!torque_est_apply_o && vel_est_apply_o))
    else $error("Velocity only mode output wrong.");
  accel_ref_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (mode_o == MODE_ACCEL_FB) |-> !accel_ref_connect_o)
    else $error("Acceleration reference connected in feedback mode.");
  fb_gain_lock_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (clk_en_i && mode_r != MODE_ACCEL_FB) |=> $stable(fb_gain_r))
    else $error("Feedback gain changed outside feedback mode.");
  prop_bw_max_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    prop_bw_o <= PROP_BW_MAX)
    else $error("Proportional bandwidth above limit.");
  lpf_std_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (clk_en_i && !lpf_ovr_r && lpf_bw_r == GAIN_RESET) |=> (lpf_bw_eff_o == LPF_BW_LIMIT_STD && !lpf_bypass_o))
    else $error("Standard filter bandwidth wrong.");
  lpf_bypass_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (clk_en_i && lpf_ovr_r && lpf_bw_r == GAIN_RESET) |=> lpf_bypass_o)
    else $error("Filter not bypassed.");
  lpf_ext_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    lpf_bw_eff_o <= LPF_BW_LIMIT_EXT)
    else $error("Filter bandwidth above extended limit.");
  // A write followed by a low enable on the next update is not judged at all, so frozen loops never fire it.
  write_lands_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (clk_en_i && wr_en_i && wr_idx_i == IDX_MODE && wr_data_i[2:0] <= MODE_ACCEL_FB) ##1 clk_en_i
    |=> mode_o == $past(wr_data_i[2:0], 2))
    else $error("Mode write did not land on the next update.");
  // Codes 5 to 7 decode to all-off, so a stray mode write can never inject an estimate.
  mode_accel_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (mode_o == MODE_ACCEL_FB) |-> (torque_est_apply_o && !vel_est_apply_o && input_gain_o == AUTO_GAIN_OFF))
    else $error("Acceleration feedback mode output wrong.");
  auto_gain_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (mode_o == MODE_TORQUE_ONLY || mode_o == MODE_TORQUE_VEL || mode_o == MODE_VEL_ONLY)
    |-> (feedback_gain_o == AUTO_GAIN_ON && input_gain_o == AUTO_GAIN_ON))
    else $error("Internal observer gains wrong.");
  fb_gain_max_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    feedback_gain_o <= FB_GAIN_MAX)
    else $error("Feedback gain above limit.");
  pos_fb_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (mode_o != MODE_DISABLED) |-> pos_fb_connect_o)
    else $error("Position feedback not connected to the observer.");
  lpf_limit_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (clk_en_i && !lpf_ovr_r) |=> (lpf_bw_eff_o <= LPF_BW_LIMIT_STD))
    else $error("Filter bandwidth above standard limit.");
  prop_store_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (clk_en_i && wr_en_i && wr_idx_i == IDX_PROP_BW) |=> (prop_bw_r == $past(wr_data_i)))
    else $error("Proportional bandwidth not stored as written.");
endmodule

// >>> observer_pkg.sv
// Constants shared by the load observer configuration block.
// Assumes a single control-loop clock and a parameter message port driven by the controller.
package observer_pkg;
  localparam int PARAM_IDX_W = 3;
  localparam logic [2:0] IDX_MODE = 3'h0;
  localparam logic [2:0] IDX_PROP_BW = 3'h1;
  localparam logic [2:0] IDX_INT_BW = 3'h2;
  localparam logic [2:0] IDX_FB_GAIN = 3'h3;
  localparam logic [2:0] IDX_ACCEL_EST = 3'h4;
  localparam logic [2:0] IDX_TORQUE_EST = 3'h5;
  localparam logic [2:0] IDX_LPF_OVERRIDE = 3'h6;
  localparam logic [2:0] IDX_LPF_BW = 3'h7;
  localparam logic [15:0] PROP_BW_MAX = 16'h30D4;
  localparam logic [15:0] FB_GAIN_MAX = 16'h00C8;
  localparam logic [15:0] LPF_BW_LIMIT_STD = 16'h0185;
  localparam logic [15:0] LPF_BW_LIMIT_EXT = 16'h28BE;
  localparam logic [15:0] GAIN_RESET = 16'h0000;
  localparam logic [15:0] AUTO_GAIN_ON = 16'h0001;
  localparam logic [15:0] AUTO_GAIN_OFF = 16'h0000;
  typedef enum logic [2:0] {
    MODE_DISABLED = 3'b000,
    MODE_TORQUE_ONLY = 3'b001,
    MODE_TORQUE_VEL = 3'b010,
    MODE_VEL_ONLY = 3'b011,
    MODE_ACCEL_FB = 3'b100
  } obs_mode_t;
endpackage

// >>> observer_host_model.sv
// Motion controller model that writes and reads observer parameters.
// Assumes the drive takes a write at an enabled rising edge and answers reads one edge later.
`timescale 1ns/10ps
module observer_host_model
  import observer_pkg::*;
(
  // Clock and read data.
  input wire logic clk_i,
  input wire logic [31:0] rd_data_i,
  // Parameter message port.
  output logic wr_en_o,
  output logic [PARAM_IDX_W-1:0] wr_idx_o,
  output logic [15:0] wr_data_o,
  output logic [PARAM_IDX_W-1:0] rd_idx_o
);
  initial begin
    wr_en_o = 1'b0;
    wr_idx_o = 3'h0;
    wr_data_o = 16'h0000;
    rd_idx_o = 3'h0;
  end
  // An unchecked write is how a scenario probes that the drive itself never rejects an out-of-range value.
  task automatic put(input logic [2:0] idx, input logic [15:0] data, input bit chk);
    @(posedge clk_i);
    if (chk && idx == IDX_PROP_BW && data > PROP_BW_MAX) data = PROP_BW_MAX;
    if (chk && idx == IDX_FB_GAIN && data > FB_GAIN_MAX) data = FB_GAIN_MAX;
    wr_en_o <= 1'b1;
    wr_idx_o <= idx;
    wr_data_o <= data;
    @(posedge clk_i);
    wr_en_o <= 1'b0;
    wr_data_o <= ~data;
  endtask
  task automatic get(input logic [2:0] idx, output logic [31:0] data);
    @(posedge clk_i);
    rd_idx_o <= idx;
    repeat (2) @(posedge clk_i);
    #1 data = rd_data_i;
  endtask
endmodule

// >>> load_observer_config_test.sv
// Self-checking testbench for the load observer configuration block.
// Assumes the controller model drives the message port; estimates come from this bench.
`timescale 1ns/10ps
module load_observer_config_test;
  import observer_pkg::*;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic clk_en_i = 1'b1;
  logic [31:0] accel_est_i = 32'h0000_0000;
  logic signed [15:0] torque_est_i = 16'sh0000;
  logic wr_en;
  logic [2:0] wr_idx;
  logic [15:0] wr_data;
  logic [2:0] rd_idx;
  logic [31:0] rd_data;
  logic [2:0] mode_o;
  logic ref_c, pos_c, trq_a, vel_a, byp;
  logic [15:0] prop_bw, int_bw, fb_gain, in_gain, lpf_bw;
  int error_cnt = 0;
  int checks_done = 0;
  logic [31:0] d;
  always #2 clk_i = ~clk_i;
  observer_host_model observer_host_model_inst (.clk_i(clk_i), .rd_data_i(rd_data), .wr_en_o(wr_en),
    .wr_idx_o(wr_idx), .wr_data_o(wr_data), .rd_idx_o(rd_idx));
  load_observer_config load_observer_config_inst (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .clk_en_i(clk_en_i), .wr_en_i(wr_en), .wr_idx_i(wr_idx), .wr_data_i(wr_data),
    .rd_idx_i(rd_idx), .rd_data_o(rd_data), .accel_est_i(accel_est_i), .torque_est_i(torque_est_i),
    .mode_o(mode_o), .accel_ref_connect_o(ref_c), .pos_fb_connect_o(pos_c),
    .torque_est_apply_o(trq_a), .vel_est_apply_o(vel_a), .prop_bw_o(prop_bw), .int_bw_o(int_bw),
    .feedback_gain_o(fb_gain), .input_gain_o(in_gain), .lpf_bypass_o(byp), .lpf_bw_eff_o(lpf_bw));
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Applied outputs follow one loop update after the write is taken.
  task automatic wr(input logic [2:0] idx, input logic [15:0] data, input bit c = 1'b0);
    observer_host_model_inst.put(idx, data, c);
    @(posedge clk_i);
    #1;
  endtask
  task automatic rd(input logic [2:0] idx);
    observer_host_model_inst.get(idx, d);
  endtask
  task automatic test_reset();
    chk("mode", mode_o, 0);
    chk("torque_apply", trq_a, 0);
    chk("vel_apply", vel_a, 0);
    chk("lpf_bw", lpf_bw, LPF_BW_LIMIT_STD);
    rd(IDX_MODE);
    chk("mode_read", d, 0);
  endtask
  task automatic test_modes();
    bit on;
    for (int m = 0; m < 6; m++) begin
      wr(IDX_MODE, 16'(m));
      on = (m >= 1 && m <= 3);
      chk("mode", mode_o, (m < 5) ? m : 0);
      chk("torque_apply", trq_a, m == 1 || m == 2 || m == 4);
      chk("vel_apply", vel_a, m == 2 || m == 3);
      chk("accel_ref", ref_c, on);
      chk("pos_fb", pos_c, m >= 1 && m <= 4);
      chk("input_gain", in_gain, on);
      chk("fb_gain", fb_gain, on);
    end
  endtask
  task automatic test_fb_gain();
    wr(IDX_MODE, 16'h0002);
    wr(IDX_FB_GAIN, 16'h0064);
    chk("fb_gain", fb_gain, 1);
    rd(IDX_FB_GAIN);
    chk("fb_read", d, 0);
    wr(IDX_MODE, 16'h0004);
    wr(IDX_FB_GAIN, 16'h012C);
    chk("fb_gain", fb_gain, FB_GAIN_MAX);
    rd(IDX_FB_GAIN);
    chk("fb_read", d, 32'h0000_012C);
    wr(IDX_FB_GAIN, 16'h0001);
    chk("fb_gain", fb_gain, 1);
  endtask
  task automatic test_gains();
    wr(IDX_PROP_BW, 16'h30D4);
    chk("prop_bw", prop_bw, 16'h30D4);
    wr(IDX_PROP_BW, 16'h30D5);
    chk("prop_bw", prop_bw, PROP_BW_MAX);
    rd(IDX_PROP_BW);
    chk("prop_read", d, 32'h0000_30D5);
    wr(IDX_PROP_BW, 16'h7000, 1'b1);
    rd(IDX_PROP_BW);
    chk("prop_read", d, 32'h0000_30D4);
    wr(IDX_INT_BW, 16'hFFFF);
    chk("int_bw", int_bw, 16'hFFFF);
    wr(IDX_INT_BW, 16'hFFFE);
    chk("int_bw", int_bw, 16'hFFFE);
    chk("prop_bw", prop_bw, PROP_BW_MAX);
    rd(IDX_INT_BW);
    chk("int_read", d, 32'h0000_FFFE);
  endtask
  task automatic test_est();
    @(posedge clk_i);
    accel_est_i <= 32'h8000_0001;
    torque_est_i <= 16'sh8001;
    wr(IDX_ACCEL_EST, 16'h1234);
    rd(IDX_ACCEL_EST);
    chk("accel_read", d, 32'h8000_0001);
    rd(IDX_TORQUE_EST);
    chk("torque_read", d, 32'hFFFF_8001);
  endtask
  task automatic lpf(input logic [15:0] ov, input logic [15:0] bw, input logic b, input logic [15:0] e);
    wr(IDX_LPF_OVERRIDE, ov);
    wr(IDX_LPF_BW, bw);
    chk("lpf_bypass", byp, b);
    if (!b) chk("lpf_bw", lpf_bw, e);
  endtask
  // A write taken just before the updates stop must wait for the next enabled update.
  task automatic test_hold();
    wr(IDX_MODE, 16'h0002);
    observer_host_model_inst.put(IDX_MODE, 16'h0003, 1'b0);
    clk_en_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    clk_en_i <= 1'b1;
    #1;
    chk("mode_hold", mode_o, 2);
    @(posedge clk_i);
    #1;
    chk("mode_land", mode_o, 3);
    @(posedge clk_i);
    reset_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    @(posedge clk_i);
    #1;
    chk("mode", mode_o, 0);
    chk("lpf_bw", lpf_bw, LPF_BW_LIMIT_STD);
  endtask
  task automatic test_lpf();
    lpf(16'h0000, 16'h0000, 1'b0, LPF_BW_LIMIT_STD);
    lpf(16'h0000, 16'h0064, 1'b0, 16'h0064);
    lpf(16'h0000, 16'h03E8, 1'b0, LPF_BW_LIMIT_STD);
    lpf(16'h0001, 16'h0000, 1'b1, 16'h0000);
    lpf(16'h0001, 16'h4E20, 1'b0, LPF_BW_LIMIT_EXT);
    lpf(16'h0001, 16'h1388, 1'b0, 16'h1388);
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #40000;
    error_cnt++;
    stop_test();
  end
  initial begin
    repeat (16) @(posedge clk_i);
    reset_n_i <= 1'b1;
    @(posedge clk_i);
    #1;
    test_reset();
    test_modes();
    test_fb_gain();
    test_gains();
    test_est();
    test_lpf();
    test_hold();
    stop_test();
  end
endmodule
